// >>> logic/aas_slice.sv
// address arithmetic slice: three working registers, output register, adder, two output ports
`timescale 1ns/1ps
`include "aas_map.svh"

module aas_slice (
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                clock_in_i,
  input  wire logic                execute_n_i,
  input  wire logic                bus_source_select_i,
  input  wire logic [2:0]          op_select_i,
  input  wire logic [`AAS_W-1:0]   operand_in_n_i,
  input  wire logic                carry_in_n_i,
  input  wire logic                addr_bus_oe_n_i,
  input  wire logic                data_bus_oe_n_i,
  output logic                     carry_out_n_o,
  output logic [`AAS_W-1:0]        addr_bus_out_o,
  output logic                     addr_bus_oe_o,
  output logic [`AAS_W-1:0]        result_out_n_o,
  output logic                     result_oe_o,
  input  wire aas_pkg::aas_avm_req_t avm_req_i,
  output aas_pkg::aas_avm_rsp_t    avm_rsp_o
);
  import aas_pkg::*;

  // --------------------------------------------------------------
  // types and decode
  // --------------------------------------------------------------
  typedef struct packed {
    logic [`AAS_W-1:0] pc;
    logic [`AAS_W-1:0] sp;
    logic [`AAS_W-1:0] op;
    logic [`AAS_W-1:0] outr;
    logic [`AAS_W-1:0] xbus;
    logic              xoe;
    logic [`AAS_W-1:0] dout_n;
    logic              doe;
    logic              co_n;
    logic              cp_prev;
    logic              ctrl_en;
    logic              waitreq;
    logic [31:0]       rdata;
  } aas_state_t;

  function automatic aas_dec_t aas_decode(input logic [2:0] code);
    aas_dec_t r;
    r = '{AAS_SEL_NONE, AAS_SEL_PC, AAS_SEL_PC};
    unique case (code)
      3'h0: r = '{AAS_SEL_PC, AAS_SEL_PC, AAS_SEL_PC};
      3'h1: r = '{AAS_SEL_PC, AAS_SEL_PC, AAS_SEL_SP};
      3'h2: r = '{AAS_SEL_PC, AAS_SEL_PC, AAS_SEL_OP};
      3'h3: r = '{AAS_SEL_SP, AAS_SEL_SP, AAS_SEL_SP};
      3'h4: r = '{AAS_SEL_NONE, AAS_SEL_OP, AAS_SEL_OP};
      3'h5: r = '{AAS_SEL_NONE, AAS_SEL_PC, AAS_SEL_PC};
      3'h6: r = '{AAS_SEL_OP, AAS_SEL_OP, AAS_SEL_OP};
      3'h7: r = '{AAS_SEL_NONE, AAS_SEL_SP, AAS_SEL_SP};
    endcase
    return r;
  endfunction

  // register read used by operand and address bus paths
  function automatic logic [`AAS_W-1:0] aas_pick(
    input aas_sel_t s, input aas_state_t st);
    logic [`AAS_W-1:0] v;
    v = '0;
    unique case (s)
      AAS_SEL_NONE: v = '0;
      AAS_SEL_PC:   v = st.pc;
      AAS_SEL_SP:   v = st.sp;
      AAS_SEL_OP:   v = st.op;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // --------------------------------------------------------------
  // datapath and register bus
  // --------------------------------------------------------------
  aas_state_t        q;
  aas_state_t        d;
  aas_dec_t          dec;
  logic [`AAS_W-1:0] opnd;
  logic              cin;
  logic [`AAS_W:0]   sum;
  logic              tick;
  logic              req;

  always_comb begin
    d    = q;
    dec  = aas_decode(op_select_i);
    opnd = ~operand_in_n_i;
    cin  = ~carry_in_n_i;
    sum  = {1'b0, aas_pick(dec.opnd, q)} + {1'b0, opnd}
           + {{`AAS_W{1'b0}}, cin};
    // gated clock rise, pin sampled on the system clock
    tick = clock_in_i & ~q.cp_prev & ~execute_n_i & q.ctrl_en;
    d.cp_prev = clock_in_i;
    // store sum into destination and output
    if (tick) begin
      unique case (dec.dest)
        AAS_SEL_PC:   d.pc = sum[`AAS_W-1:0];
        AAS_SEL_SP:   d.sp = sum[`AAS_W-1:0];
        AAS_SEL_OP:   d.op = sum[`AAS_W-1:0];
        AAS_SEL_NONE: d.pc = q.pc;
      endcase
      d.outr = sum[`AAS_W-1:0];
    end
    // address bus source, independent of tick
    d.xbus = bus_source_select_i ? sum[`AAS_W-1:0]
                                 : aas_pick(dec.xsrc, q);
    d.xoe = ~addr_bus_oe_n_i;
    // data port follows the output register
    d.doe    = ~data_bus_oe_n_i;
    d.dout_n = ~d.outr;
    // ripple carry out, low on overflow
    d.co_n = ~sum[`AAS_W];
    // one-cycle waitrequest pulse low answers every request
    req       = avm_req_i.read | avm_req_i.write;
    d.waitreq = ~(req & q.waitreq);
    if (req & q.waitreq) begin
      unique case (avm_req_i.address)
        `AAS_OFF_PC:   d.rdata = {{(32-`AAS_W){1'b0}}, q.pc};
        `AAS_OFF_SP:   d.rdata = {{(32-`AAS_W){1'b0}}, q.sp};
        `AAS_OFF_OP:   d.rdata = {{(32-`AAS_W){1'b0}}, q.op};
        `AAS_OFF_OUT:  d.rdata = {{(32-`AAS_W){1'b0}}, q.outr};
        `AAS_OFF_CTRL: d.rdata = {31'h0, q.ctrl_en};
        default:       d.rdata = 32'h0;
      endcase
    end
    // write lands at the edge where waitrequest is seen low
    if (avm_req_i.write && !q.waitreq &&
        avm_req_i.address == `AAS_OFF_CTRL) begin
      d.ctrl_en = avm_req_i.writedata[`AAS_CTRL_EN];
    end
  end

  // storage; zero on reset is one legal power-up value
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q.pc      <= `AAS_REG_RST;
      q.sp      <= `AAS_REG_RST;
      q.op      <= `AAS_REG_RST;
      q.outr    <= `AAS_REG_RST;
      q.xbus    <= 4'h0;
      q.xoe     <= 1'b0;
      q.dout_n  <= 4'hF;
      q.doe     <= 1'b0;
      q.co_n    <= 1'b1;
      q.cp_prev <= 1'b1;
      q.ctrl_en <= `AAS_CTRL_RST;
      q.waitreq <= 1'b1;
      q.rdata   <= 32'h0;
    end else begin
      q <= d;
    end
  end

  assign carry_out_n_o         = q.co_n;
  assign addr_bus_out_o        = q.xbus;
  assign addr_bus_oe_o         = q.xoe;
  assign result_out_n_o        = q.dout_n;
  assign result_oe_o           = q.doe;
  assign avm_rsp_o.readdata    = q.rdata;
  assign avm_rsp_o.waitrequest = q.waitreq;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  property p_outr_update;
    @(posedge clk_i) disable iff (!rst_n)
    tick |=> q.outr == $past(sum[`AAS_W-1:0]);
  endproperty
  a_outr_update: assert property (p_outr_update)
    else $error("output register missed the sum");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n)
    !tick |=> $stable({q.pc, q.sp, q.op, q.outr});
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a gated clock rise");

  property p_xbus_sum;
    @(posedge clk_i) disable iff (!rst_n)
    bus_source_select_i |=> addr_bus_out_o == $past(sum[`AAS_W-1:0]);
  endproperty
  a_xbus_sum: assert property (p_xbus_sum)
    else $error("address bus not showing the sum");

  property p_xbus_reg;
    @(posedge clk_i) disable iff (!rst_n)
    (!bus_source_select_i && op_select_i inside {3'h3, 3'h7})
      |=> addr_bus_out_o == $past(q.sp);
  endproperty
  a_xbus_reg: assert property (p_xbus_reg)
    else $error("address bus not showing stack pointer");

  property p_addr_oe;
    @(posedge clk_i) disable iff (!rst_n)
    addr_bus_oe_n_i ##1 addr_bus_oe_n_i |-> !addr_bus_oe_o;
  endproperty
  a_addr_oe: assert property (p_addr_oe)
    else $error("address bus driven while disabled");

  property p_data_port;
    @(posedge clk_i) disable iff (!rst_n)
    !data_bus_oe_n_i |=> result_oe_o && result_out_n_o == ~q.outr;
  endproperty
  a_data_port: assert property (p_data_port)
    else $error("data port not showing output register");

  property p_carry;
    @(posedge clk_i) disable iff (!rst_n)
    1'b1 |=> carry_out_n_o == !$past(sum[`AAS_W]);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry out wrong");

  property p_pc_to_sp;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h1)
      |=> q.sp == 4'($past(q.pc) + $past(opnd) + $past(cin))
          && $stable(q.pc);
  endproperty
  a_pc_to_sp: assert property (p_pc_to_sp)
    else $error("pc sum not stored in stack pointer");

  property p_data_only;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h4)
      |=> q.op == 4'($past(opnd) + $past(cin));
  endproperty
  a_data_only: assert property (p_data_only)
    else $error("operand register load wrong");

  property p_pc_inc;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h0)
      |=> q.pc == 4'($past(q.pc) + $past(opnd) + $past(cin));
  endproperty
  a_pc_inc: assert property (p_pc_inc)
    else $error("pc sum not stored in program counter");

  property p_pc_to_op;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h2)
      |=> q.op == 4'($past(q.pc) + $past(opnd) + $past(cin))
          && $stable(q.pc);
  endproperty
  a_pc_to_op: assert property (p_pc_to_op)
    else $error("pc sum not stored in operand register");

  property p_sp_add;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h3)
      |=> q.sp == 4'($past(q.sp) + $past(opnd) + $past(cin));
  endproperty
  a_sp_add: assert property (p_sp_add)
    else $error("stack pointer sum wrong");

  property p_pc_load;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h5)
      |=> q.pc == 4'($past(opnd) + $past(cin));
  endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("program counter load wrong");

  property p_op_add;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h6)
      |=> q.op == 4'($past(q.op) + $past(opnd) + $past(cin));
  endproperty
  a_op_add: assert property (p_op_add)
    else $error("operand register sum wrong");

  property p_sp_load;
    @(posedge clk_i) disable iff (!rst_n)
    (tick && op_select_i == 3'h7)
      |=> q.sp == 4'($past(opnd) + $past(cin));
  endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("stack pointer load wrong");

  property p_xbus_pc;
    @(posedge clk_i) disable iff (!rst_n)
    (!bus_source_select_i && op_select_i inside {3'h0, 3'h1, 3'h2, 3'h5})
      |=> addr_bus_out_o == $past(q.pc);
  endproperty
  a_xbus_pc: assert property (p_xbus_pc)
    else $error("address bus not showing program counter");

  property p_xbus_op;
    @(posedge clk_i) disable iff (!rst_n)
    (!bus_source_select_i && op_select_i inside {3'h4, 3'h6})
      |=> addr_bus_out_o == $past(q.op);
  endproperty
  a_xbus_op: assert property (p_xbus_op)
    else $error("address bus not showing operand register");

  property p_data_off;
    @(posedge clk_i) disable iff (!rst_n)
    data_bus_oe_n_i |=> !result_oe_o;
  endproperty
  a_data_off: assert property (p_data_off)
    else $error("data port driven while disabled");

  property p_bus_answer;
    @(posedge clk_i) disable iff (!rst_n)
    (req && q.waitreq) |=> !q.waitreq ##1 q.waitreq;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle");

  c_fetch: cover property (@(posedge clk_i) disable iff (!rst_n)
    tick && op_select_i == 3'h0 && bus_source_select_i == 1'b0);
  c_overflow: cover property (@(posedge clk_i) disable iff (!rst_n)
    tick && sum[`AAS_W]);
  c_bus_read: cover property (@(posedge clk_i) disable iff (!rst_n)
    avm_req_i.read && !q.waitreq);
  c_refused: cover property (@(posedge clk_i) disable iff (!rst_n)
    clock_in_i && !q.cp_prev && execute_n_i);
  c_sum_on_bus: cover property (@(posedge clk_i) disable iff (!rst_n)
    tick && bus_source_select_i && !addr_bus_oe_n_i);

endmodule // aas_slice

// >>> logic/aas_map.svh
// offsets, field positions and reset values of the address slice
`ifndef AAS_MAP_SVH
`define AAS_MAP_SVH

// datapath width of one slice
`define AAS_W          4
// avalon byte addresses (one aligned word each)
`define AAS_ADDR_W     5
`define AAS_OFF_PC     5'h00
`define AAS_OFF_SP     5'h04
`define AAS_OFF_OP     5'h08
`define AAS_OFF_OUT    5'h0C
`define AAS_OFF_CTRL   5'h10
// control register: bit 0 lets microcycles update the registers
`define AAS_CTRL_EN    0
`define AAS_CTRL_RST   1'h1
`define AAS_REG_RST    4'h0

`endif

// >>> logic/aas_pkg.sv
// types shared by the address arithmetic slice
`include "aas_map.svh"

package aas_pkg;

  // register chosen as operand, as bus source or as destination
  typedef enum logic [1:0] {
    AAS_SEL_NONE = 2'h0,
    AAS_SEL_PC   = 2'h1,
    AAS_SEL_SP   = 2'h2,
    AAS_SEL_OP   = 2'h3
  } aas_sel_t;

  typedef struct packed {
    aas_sel_t opnd;
    aas_sel_t xsrc;
    aas_sel_t dest;
  } aas_dec_t;

  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [`AAS_ADDR_W-1:0] address;
    logic [31:0]            writedata;
  } aas_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } aas_avm_rsp_t;

endpackage : aas_pkg

// >>> tb/aas_ctl_model.sv
// behavioural microprogram controller driving the slice pins
`timescale 1ns/1ps

module aas_ctl_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] op_i,
  input  wire logic [3:0] d_i,
  input  wire logic       cin_i,
  input  wire logic       bs_i,
  input  wire logic       exe_i,
  output logic            clock_in_o,
  output logic            execute_n_o,
  output logic            bsel_o,
  output logic [2:0]      op_o,
  output logic [3:0]      operand_n_o,
  output logic            carry_n_o,
  output logic            done_o
);
  logic [1:0] ph_q;

  initial begin
    ph_q = 2'h0;
    clock_in_o = 1'b0;
    execute_n_o = 1'b1;
    bsel_o = 1'b0;
    op_o = 3'h0;
    operand_n_o = 4'hF;
    carry_n_o = 1'b1;
    done_o = 1'b0;
  end

  // --------------------
  // microcycle sequencer
  // --------------------
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (ph_q == 2'h0 && go_i) begin
      operand_n_o <= ~d_i;
      carry_n_o <= !cin_i;
      op_o <= op_i;
      bsel_o <= bs_i;
      ph_q <= 2'h1;
    end else if (ph_q == 2'h1) begin
      clock_in_o <= 1'b1;
      execute_n_o <= !exe_i;
      ph_q <= 2'h2;
    end else if (ph_q == 2'h2) begin
      clock_in_o <= 1'b0;
      execute_n_o <= 1'b1;
      done_o <= 1'b1;
      ph_q <= 2'h0;
    end
  end
endmodule // aas_ctl_model

// >>> tb/address_arithmetic_slice_tb_top.sv
// self-checking testbench of the address arithmetic slice
`timescale 1ns/1ps

module address_arithmetic_slice_tb_top;
  import aas_pkg::*;

  // --------------------
  // signals
  // --------------------
  logic         clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic         go = 1'b0;
  logic [2:0]   m_op = 3'h0;
  logic [3:0]   m_d = 4'h0;
  logic         m_cin = 1'b0, m_bs = 1'b0, m_exe = 1'b0;
  logic         aoe_n = 1'b0, doe_n = 1'b0;
  logic         done, clk_in, exe_n, bsel, cin_n, cout_n, a_oe, r_oe;
  logic [2:0]   op;
  logic [3:0]   d_n, abus, res_n;
  aas_avm_req_t req = '0;
  aas_avm_rsp_t rsp;
  logic [3:0]   r [4] = '{default: 4'h0};
  logic [3:0]   outr = 4'h0;
  logic         en = 1'b1;
  int           n_mismatch = 0;
  int           n_checks = 0;
  // operand, destination and bus source per code; 3 means none
  int           opn [8] = '{0, 0, 0, 1, 3, 3, 2, 3};
  int           dst [8] = '{0, 1, 2, 1, 2, 0, 2, 1};
  int           xs [8] = '{0, 0, 0, 1, 2, 0, 2, 1};

  initial forever #4 clk_i = ~clk_i;

  aas_ctl_model i_ctl (
    .clk_i(clk_i), .go_i(go), .op_i(m_op), .d_i(m_d), .cin_i(m_cin),
    .bs_i(m_bs), .exe_i(m_exe), .clock_in_o(clk_in), .execute_n_o(exe_n),
    .bsel_o(bsel), .op_o(op), .operand_n_o(d_n), .carry_n_o(cin_n),
    .done_o(done)
  );

  aas_slice i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .clock_in_i(clk_in),
    .execute_n_i(exe_n), .bus_source_select_i(bsel),
    .op_select_i(op), .operand_in_n_i(d_n), .carry_in_n_i(cin_n),
    .addr_bus_oe_n_i(aoe_n), .data_bus_oe_n_i(doe_n),
    .carry_out_n_o(cout_n), .addr_bus_out_o(abus), .addr_bus_oe_o(a_oe),
    .result_out_n_o(res_n), .result_oe_o(r_oe),
    .avm_req_i(req), .avm_rsp_o(rsp)
  );

  // --------------------
  // tasks
  // --------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= wd;
    do begin
      @(posedge clk_i);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask

  task automatic mc(input logic [2:0] c, input logic [3:0] d,
                    input logic cin, input logic bs, input logic exe);
    logic [4:0] s;
    s = r[opn[c]] + d + cin;
    if (exe && en) begin
      r[dst[c]] = s[3:0];
      outr = s[3:0];
    end
    @(posedge clk_i);
    go <= 1'b1;
    m_op <= c;
    m_d <= d;
    m_cin <= cin;
    m_bs <= bs;
    m_exe <= exe;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(negedge clk_i);
    end while (done !== 1'b1);
    repeat (3) @(negedge clk_i);
    // inputs still held, so the bus shows the sum with the new registers
    s = r[opn[c]] + d + cin;
    chk(res_n, outr ^ 4'hF);
    chk(abus, bs ? s[3:0] : r[xs[c]]);
    chk(cout_n, !s[4]);
    rd(5'(dst[c] * 4), r[dst[c]]);
    rd(5'h0C, outr);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------
  // sequence
  // --------------------
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 5; i++) rd(5'(i * 4), 32'(i == 4));
    rd(5'h14, 32'h0);
    wr(5'h04, 32'h7);
    rd(5'h04, 32'h0);
    for (int i = 0; i < 16; i++) begin
      mc(3'(i >> 1), 4'(i * 7 + 3), 1'(i >> 2), 1'(i), 1'b1);
    end
    mc(3'h0, 4'h1, 1'b0, 1'b0, 1'b1);
    mc(3'h5, 4'hF, 1'b1, 1'b1, 1'b1);
    mc(3'h3, 4'h2, 1'b1, 1'b0, 1'b0);
    wr(5'h10, 32'h0);
    en = 1'b0;
    rd(5'h10, 32'h0);
    mc(3'h6, 4'h5, 1'b0, 1'b1, 1'b1);
    wr(5'h10, 32'h1);
    en = 1'b1;
    mc(3'h4, 4'h9, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      aoe_n <= i[0];
      doe_n <= !i[0];
      repeat (3) @(negedge clk_i);
      chk(a_oe, !i[0]);
      chk(r_oe, i[0]);
    end
    test_done;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    test_done;
  end
endmodule // address_arithmetic_slice_tb_top
